// *** hpp_host_model.sv ***
// Host processor model for the host parallel port
`timescale 1ns/100ps
module hpp_host_model (
    // Clock
    input  wire logic                 clk_sys,
    // Host bus
    output hpp_pkg::hpp_host_strobe_t host_strobe,
    output logic [hpp_pkg::HA_W-1:0]  host_ad_in,
    output logic [2:0]                host_addr_in,
    // Host-side control bits
    output logic                      rx_request_enable,
    output logic                      tx_request_enable,
    output logic                      split_request_select
);
    // Idle bus, no requests enabled
    // The host sees no DMA signal and must poll its data registers
    initial begin
        host_strobe = 6'h3E;
        host_ad_in = 11'h000;
        host_addr_in = 3'h0;
        rx_request_enable = 1'b0;
        tx_request_enable = 1'b0;
        split_request_select = 1'b0;
    end
    // Request enables and split select, changed after an edge
    task automatic set_ctl(input logic rx, input logic tx, input logic split);
        @(posedge clk_sys);
        rx_request_enable <= rx;
        tx_request_enable <= tx;
        split_request_select <= split;
    endtask
    // Strobes and address lines, held until the next call
    task automatic set_bus(input logic [5:0] s, input logic [10:0] ad, input logic [2:0] a);
        @(posedge clk_sys);
        host_strobe <= s;
        host_ad_in <= ad;
        host_addr_in <= a;
    endtask
endmodule

// *** hpp_pkg.sv ***
// Constants and carrier types for the host parallel port setup and request block
package hpp_pkg;
    // Core-side register addresses
    localparam logic [23:0] ADDR_SETUP  = 24'hFFFFC4;
    localparam logic [23:0] ADDR_BASE   = 24'hFFFFC5;
    localparam logic [23:0] ADDR_PINVAL = 24'hFFFFC8;
    localparam logic [23:0] ADDR_PINDIR = 24'hFFFFC9;
    // Setup control bit positions
    localparam int SC_REQ_EN   = 4;
    localparam int SC_ACTIVE   = 6;
    localparam int SC_OPEN_DR  = 8;
    localparam int SC_DS_POL   = 9;
    localparam int SC_AS_POL   = 10;
    localparam int SC_MUXED    = 11;
    localparam int SC_DUAL_STB = 12;
    localparam int SC_SEL_POL  = 13;
    // Writable setup bits; bit 7 and others are reserved
    localparam logic [15:0] SETUP_MASK  = 16'h3F50;
    localparam logic [15:0] SETUP_RESET = 16'h0000;
    localparam logic [7:0]  BASE_RESET  = 8'h80;
    localparam logic [15:0] PIN_RESET   = 16'h0000;
    // Base field covers host address bits 10..3
    localparam int HA_LO = 3;
    localparam int HA_HI = 10;
    localparam int HA_W  = 11;
    // DMA trigger codes
    localparam logic [4:0] DMA_RX_FULL  = 5'h13;
    localparam logic [4:0] DMA_TX_EMPTY = 5'h14;

    // Core-side register access
    typedef struct packed {
        logic [23:0] addr;
        logic        wr;
        logic        rd;
        logic [15:0] wdata;
    } hpp_core_req_t;

    // Host bus strobes
    typedef struct packed {
        logic select;
        logic addr_strobe;
        logic single_strobe;
        logic read_strobe;
        logic write_strobe;
        logic read_not_write;
    } hpp_host_strobe_t;
endpackage

// *** hpp_port.sv ***
// Host parallel port: setup registers, pin fallback, select decode and requests
`timescale 1ns/100ps

module hpp_port #(
    parameter int PINS = 16,
    parameter int RAW  = 3
) (
    // Clock, reset, enable
    input  wire logic                      clk_sys,
    input  wire logic                      rst_n,
    input  wire logic                      clk_en,
    // Core-side register port
    input  wire hpp_pkg::hpp_core_req_t    core_req,
    output logic [15:0]                    core_rdata,
    // Transfer status and host-side control bits
    input  wire logic                      receive_full_flag,
    input  wire logic                      transmit_empty_flag,
    input  wire logic                      rx_request_enable,
    input  wire logic                      tx_request_enable,
    input  wire logic                      split_request_select,
    // DMA trigger
    input  wire logic [4:0]                dma_trigger_select,
    output logic                           dma_request,
    // Host bus inputs
    input  wire hpp_pkg::hpp_host_strobe_t host_strobe,
    input  wire logic [hpp_pkg::HA_W-1:0]  host_ad_in,
    input  wire logic [RAW-1:0]            host_addr_in,
    // Decoded host access
    output logic                           host_selected,
    output logic [RAW-1:0]                 host_reg_addr,
    output logic                           host_read_active,
    output logic                           host_write_active,
    // Request pins, asserted low
    output logic                           req0_out,
    output logic                           req0_oe,
    output logic                           req1_out,
    output logic                           req1_oe,
    // Port pins in GPIO fallback
    input  wire logic [PINS-1:0]           pin_in,
    output logic [PINS-1:0]                pin_out,
    output logic [PINS-1:0]                pin_oe
);
    // Level to active under a polarity bit: pol clear means active low
    function automatic logic act(input logic lvl, input logic pol);
        act = pol ? lvl : ~lvl;
    endfunction

    logic [15:0]             setup_q;
    logic [7:0]              base_q;
    logic [PINS-1:0]         pdir_q;
    logic [PINS-1:0]         pval_q;
    logic [15:0]             rdata_q;
    logic [hpp_pkg::HA_W-1:0] alat_q;
    logic                    sel_q;
    logic [RAW-1:0]          radr_q;
    logic                    rd_q;
    logic                    wr_q;
    logic                    dma_q;
    logic [1:0]              req_q;

    // Named control fields
    wire active   = setup_q[hpp_pkg::SC_ACTIVE];
    wire req_en   = setup_q[hpp_pkg::SC_REQ_EN];
    wire open_dr  = setup_q[hpp_pkg::SC_OPEN_DR];
    wire ds_pol   = setup_q[hpp_pkg::SC_DS_POL];
    wire as_pol   = setup_q[hpp_pkg::SC_AS_POL];
    wire muxed    = setup_q[hpp_pkg::SC_MUXED];
    wire dual_stb = setup_q[hpp_pkg::SC_DUAL_STB];
    wire sel_pol  = setup_q[hpp_pkg::SC_SEL_POL];

    // Core-side address decode
    wire hit_setup = core_req.addr == hpp_pkg::ADDR_SETUP;
    wire hit_base  = core_req.addr == hpp_pkg::ADDR_BASE;
    wire hit_pval  = core_req.addr == hpp_pkg::ADDR_PINVAL;
    wire hit_pdir  = core_req.addr == hpp_pkg::ADDR_PINDIR;
    wire wr_ok     = clk_en && core_req.wr;

    // Pin value read: output bits read back, GPIO inputs read the pin
    wire [PINS-1:0] gpio_mask = active ? '0 : '1;
    wire [PINS-1:0] pval_rd   = (pdir_q & pval_q)
                              | (~pdir_q & gpio_mask & pin_in);

    // Read multiplexer, unmapped addresses read zero
    wire [15:0] rd_mux =
        hit_setup ? (setup_q & hpp_pkg::SETUP_MASK) :
        hit_base  ? {8'h00, base_q} :
        hit_pval  ? 16'(pval_rd) :
        hit_pdir  ? 16'(pdir_q) : 16'h0000;

    // Core-side register writes
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            setup_q <= hpp_pkg::SETUP_RESET;
            base_q  <= hpp_pkg::BASE_RESET;
            pdir_q  <= PINS'(hpp_pkg::PIN_RESET);
            pval_q  <= PINS'(hpp_pkg::PIN_RESET);
        end else if (wr_ok) begin
            if (hit_setup) setup_q <= core_req.wdata & hpp_pkg::SETUP_MASK;
            if (hit_base)  base_q  <= core_req.wdata[7:0];
            if (hit_pdir)  pdir_q  <= core_req.wdata[PINS-1:0];
            if (hit_pval)  pval_q  <= core_req.wdata[PINS-1:0];
        end
    end

    // Registered read data
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rdata_q <= 16'h0000;
        end else if (clk_en && core_req.rd) begin
            rdata_q <= rd_mux;
        end
    end
    assign core_rdata = rdata_q;

    // GPIO drive only while the port is inactive
    assign pin_out = pval_q & gpio_mask;
    assign pin_oe  = pdir_q & gpio_mask;

    // Host-side decode
    wire as_act   = act(host_strobe.addr_strobe, as_pol);
    wire [hpp_pkg::HA_W-1:0] ha = as_act ? host_ad_in : alat_q;
    wire base_hit = ha[hpp_pkg::HA_HI:hpp_pkg::HA_LO] == base_q;
    wire pin_sel  = act(host_strobe.select, sel_pol);
    wire sel_d    = active && (muxed ? base_hit : pin_sel);
    wire [RAW-1:0] radr_d = muxed ? ha[RAW-1:0] : host_addr_in;
    wire ds_act   = act(host_strobe.single_strobe, ds_pol);
    wire rd_stb   = act(host_strobe.read_strobe, ds_pol);
    wire wr_stb   = act(host_strobe.write_strobe, ds_pol);
    wire rd_d     = dual_stb ? rd_stb : ds_act && host_strobe.read_not_write;
    wire wr_d     = dual_stb ? wr_stb : ds_act && !host_strobe.read_not_write;

    // Address latch and decoded access
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            alat_q <= '0;
            sel_q  <= 1'b0;
            radr_q <= '0;
            rd_q   <= 1'b0;
            wr_q   <= 1'b0;
        end else if (clk_en) begin
            if (muxed && as_act) alat_q <= host_ad_in;
            sel_q  <= sel_d;
            radr_q <= radr_d;
            rd_q   <= sel_d && rd_d;
            wr_q   <= sel_d && wr_d;
        end
    end
    assign host_selected     = sel_q;
    assign host_reg_addr     = radr_q;
    assign host_read_active  = rd_q;
    assign host_write_active = wr_q;

    // Request conditions; DMA triggers are core-side only
    wire req_on  = active && req_en;
    wire rx_cond = receive_full_flag && rx_request_enable && req_on;
    wire tx_cond = transmit_empty_flag && tx_request_enable && req_on;
    wire dma_d   = (dma_trigger_select == hpp_pkg::DMA_RX_FULL && receive_full_flag)
                || (dma_trigger_select == hpp_pkg::DMA_TX_EMPTY && transmit_empty_flag);
    wire [1:0] req_d = split_request_select ? {rx_cond, tx_cond}
                                            : {1'b0, rx_cond || tx_cond};

    // Registered request and DMA state
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            req_q <= 2'b00;
            dma_q <= 1'b0;
        end else if (clk_en) begin
            req_q <= req_d;
            dma_q <= dma_d;
        end
    end
    assign dma_request = dma_q;

    // Pin drive: push-pull drives both levels, open drain only pulls low
    assign req0_out = ~req_q[0];
    assign req1_out = ~req_q[1];
    assign req0_oe  = req_on && (!open_dr || req_q[0]);
    assign req1_oe  = req_on && split_request_select && (!open_dr || req_q[1]);

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_rx_ready;
        clk_en && receive_full_flag && rx_request_enable && req_on;
    endsequence

    property p_req_needs_enable;
        req_q != 2'b00 |-> $past(req_on);
    endproperty
    a_req_needs_enable: assert property (p_req_needs_enable)
        else $error("request without enable");

    property p_rx_request;
        s_rx_ready ##0 !split_request_select |=> req_q[0];
    endproperty
    a_rx_request: assert property (p_rx_request)
        else $error("receive request missing");

    property p_split_second;
        clk_en && !split_request_select |=> !req_q[1];
    endproperty
    a_split_second: assert property (p_split_second)
        else $error("second line used in combined mode");

    property p_dma_code;
        clk_en && dma_trigger_select == hpp_pkg::DMA_RX_FULL && receive_full_flag
            |=> dma_request;
    endproperty
    a_dma_code: assert property (p_dma_code)
        else $error("receive DMA trigger missing");

    property p_base_upper;
        clk_en && core_req.rd && hit_base |=> core_rdata[15:8] == 8'h00;
    endproperty
    a_base_upper: assert property (p_base_upper)
        else $error("base upper bits not zero");

    property p_gpio_drive;
        !active |-> pin_oe == pdir_q && pin_out == pval_q;
    endproperty
    a_gpio_drive: assert property (p_gpio_drive)
        else $error("GPIO drive wrong while inactive");

    property p_pin_input;
        clk_en && core_req.rd && hit_pval && !active
            |=> core_rdata[0] == (pdir_q[0] ? pval_q[0] : $past(pin_in[0]));
    endproperty
    a_pin_input: assert property (p_pin_input)
        else $error("pin read value wrong");

    property p_open_drain;
        open_dr && req0_oe |-> !req0_out;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("open drain line driven high");

    property p_select_pol;
        clk_en && active && !muxed && act(host_strobe.select, sel_pol) |=> host_selected;
    endproperty
    a_select_pol: assert property (p_select_pol)
        else $error("select polarity not honoured");

    property p_inactive_idle;
        clk_en && !active |=> !host_selected && !host_read_active && !host_write_active;
    endproperty
    a_inactive_idle: assert property (p_inactive_idle)
        else $error("select while port inactive");
endmodule

// *** tb_hpp_port.sv ***
// Self-checking bench for the host parallel port block
`timescale 1ns/100ps
module tb_hpp_port;
    logic                      clk_sys;
    logic                      clk_en;
    logic                      rst_n;
    hpp_pkg::hpp_core_req_t    core_req;
    logic [15:0]               core_rdata, pin_in, pin_out, pin_oe;
    logic                      rx_full, tx_empty, rx_en, tx_en, split, dma_request;
    logic [4:0]                dma_sel;
    hpp_pkg::hpp_host_strobe_t host_strobe;
    logic [10:0]               host_ad_in;
    logic [2:0]                host_addr_in, reg_addr;
    logic                      selected, rd_act, wr_act;
    logic                      req0_out, req0_oe, req1_out, req1_oe;
    int                        num_errors = 0;
    int                        comparisons = 0;
    int                        cycles = 0;
    // Request pins are pulled up when released
    wire                       req0_line = req0_oe ? req0_out : 1'b1;
    wire                       req1_line = req1_oe ? req1_out : 1'b1;

    hpp_port uut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .core_req(core_req),
        .core_rdata(core_rdata), .receive_full_flag(rx_full), .transmit_empty_flag(tx_empty),
        .rx_request_enable(rx_en), .tx_request_enable(tx_en), .split_request_select(split),
        .dma_trigger_select(dma_sel), .dma_request(dma_request), .host_strobe(host_strobe),
        .host_ad_in(host_ad_in), .host_addr_in(host_addr_in), .host_selected(selected),
        .host_reg_addr(reg_addr), .host_read_active(rd_act), .host_write_active(wr_act),
        .req0_out(req0_out), .req0_oe(req0_oe), .req1_out(req1_out), .req1_oe(req1_oe),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
    hpp_host_model host (.clk_sys(clk_sys), .host_strobe(host_strobe),
        .host_ad_in(host_ad_in), .host_addr_in(host_addr_in), .rx_request_enable(rx_en),
        .tx_request_enable(tx_en), .split_request_select(split));

    // Clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Counted comparison
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Core register write and read
    task automatic wr(input logic [23:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        core_req <= '{a, 1'b1, 1'b0, d};
        @(posedge clk_sys);
        core_req <= '{a, 1'b0, 1'b0, d};
    endtask
    task automatic rd(input logic [23:0] a, input logic [15:0] exp);
        @(posedge clk_sys);
        core_req <= '{a, 1'b0, 1'b1, 16'h0000};
        @(posedge clk_sys);
        core_req <= '{a, 1'b0, 1'b0, 16'h0000};
        #1 chk(core_rdata, exp);
    endtask
    // Let registered outputs follow new inputs
    task automatic settle;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask
    // Request pins packed as line0, oe0, line1, oe1
    task automatic chk_req(input logic [15:0] exp);
        settle();
        chk({12'h000, req0_line, req0_oe, req1_line, req1_oe}, exp);
    endtask
    // Host decode packed as selected, read, write, register address
    task automatic chk_dec(input logic [15:0] exp);
        settle();
        chk({10'h000, selected, rd_act, wr_act, reg_addr}, exp);
    endtask
    // Verdict
    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            give_verdict();
        end
    end

    // Test sequence
    initial begin
        rst_n <= 1'b0;
        clk_en <= 1'b1;
        core_req <= '0;
        {rx_full, tx_empty} <= 2'b00;
        dma_sel <= 5'h00;
        pin_in <= 16'hAB00;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(hpp_pkg::ADDR_BASE, 16'h0080);
        rd(hpp_pkg::ADDR_SETUP, 16'h0000);
        rd(24'hFFFFC7, 16'h0000);
        wr(hpp_pkg::ADDR_BASE, 16'hFF12);
        rd(hpp_pkg::ADDR_BASE, 16'h0012);
        wr(hpp_pkg::ADDR_SETUP, 16'hFFFF);
        rd(hpp_pkg::ADDR_SETUP, 16'h3F50);
        wr(hpp_pkg::ADDR_SETUP, 16'h0000);
        // A write while the clock enable is low must not land
        @(posedge clk_sys) clk_en <= 1'b0;
        wr(hpp_pkg::ADDR_BASE, 16'h0055);
        clk_en <= 1'b1;
        rd(hpp_pkg::ADDR_BASE, 16'h0012);
        // Second reset in mid-run brings the base back to its reset value
        @(posedge clk_sys) rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(hpp_pkg::ADDR_BASE, 16'h0080);
        $display("test registers done");
        wr(hpp_pkg::ADDR_PINDIR, 16'h00FF);
        wr(hpp_pkg::ADDR_PINVAL, 16'h1234);
        rd(hpp_pkg::ADDR_PINVAL, 16'hAB34);
        chk(pin_oe, 16'h00FF);
        chk(pin_out & 16'h00FF, 16'h0034);
        wr(hpp_pkg::ADDR_SETUP, 16'h0040);
        settle();
        chk(pin_oe, 16'h0000);
        rd(hpp_pkg::ADDR_PINVAL, 16'h0034);
        $display("test pins done");
        for (int i = 0; i < 2; i++) begin
            @(posedge clk_sys);
            dma_sel <= i ? hpp_pkg::DMA_TX_EMPTY : hpp_pkg::DMA_RX_FULL;
            {rx_full, tx_empty} <= i ? 2'b01 : 2'b10;
            settle();
            chk({15'h0000, dma_request}, 16'h0001);
            @(posedge clk_sys) {rx_full, tx_empty} <= i ? 2'b10 : 2'b01;
            settle();
            chk({15'h0000, dma_request}, 16'h0000);
        end
        $display("test dma done");
        host.set_ctl(1'b1, 1'b1, 1'b0);
        wr(hpp_pkg::ADDR_SETUP, 16'h0050);
        chk_req(16'h0006);
        @(posedge clk_sys) {rx_full, tx_empty} <= 2'b00;
        chk_req(16'h000E);
        wr(hpp_pkg::ADDR_SETUP, 16'h0150);
        chk_req(16'h000A);
        @(posedge clk_sys) {rx_full, tx_empty} <= 2'b01;
        chk_req(16'h0006);
        wr(hpp_pkg::ADDR_SETUP, 16'h0050);
        host.set_ctl(1'b1, 1'b1, 1'b1);
        {rx_full, tx_empty} <= 2'b10;
        chk_req(16'h000D);
        host.set_ctl(1'b0, 1'b1, 1'b1);
        chk_req(16'h000F);
        wr(hpp_pkg::ADDR_SETUP, 16'h0040);
        chk_req(16'h000A);
        $display("test requests done");
        host.set_bus(6'h17, 11'h000, 3'h6);
        chk_dec(16'h0036);
        wr(hpp_pkg::ADDR_SETUP, 16'h1240);
        host.set_bus(6'h12, 11'h000, 3'h2);
        chk_dec(16'h002A);
        wr(hpp_pkg::ADDR_SETUP, 16'h2040);
        chk_dec(16'h0002);
        host.set_bus(6'h37, 11'h000, 3'h1);
        chk_dec(16'h0031);
        wr(hpp_pkg::ADDR_SETUP, 16'h0840);
        wr(hpp_pkg::ADDR_BASE, 16'h0080);
        host.set_bus(6'h0F, 11'h405, 3'h0);
        chk_dec(16'h0025);
        host.set_bus(6'h1F, 11'h7FF, 3'h0);
        chk_dec(16'h0025);
        wr(hpp_pkg::ADDR_BASE, 16'h0021);
        settle();
        chk({15'h0000, selected}, 16'h0000);
        $display("test host decode done");
        give_verdict();
    end
endmodule
